// ---- hdl/ipv_ctrl.sv ----
// Purpose: Posted flags, source masks, soft posting and vector encoder
// Assumes: Sources come from logic on pclk; gpio events are levels
// Notes: Single clock; APB slave answers with zero wait states
`timescale 1ns/100ps

module ipv_ctrl #(
  parameter int NUM_GPIO = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ipv_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources
  input wire ipv_pkg::ipv_src_t src_in,
  input wire ipv_pkg::ipv_timer_src_t timer_src_in,
  // Core side
  input wire logic global_irq_enable,
  input wire logic vector_take,
  output logic core_irq_req,
  output logic [7:0] core_vector,
  // Summary interrupt
  output logic irq
);

  // ==========================================================================
  // Bus decode
  logic wr_en;
  logic rd_en;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic lane0;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign idx = paddr[ipv_pkg::ADDR_W-1:2];
  assign wbyte = pwdata[7:0];
  assign lane0 = pstrb[0];
  assign pready = 1'b1;

  // ==========================================================================
  // Source vector in register bit order
  logic [NUM_GPIO-1:0] gpio_prev_ff;
  logic [NUM_GPIO-1:0] nxt_gpio_prev;
  logic [NUM_GPIO-1:0] gpio_edge;
  logic [23:0] hw_evt;

  always_comb begin
    nxt_gpio_prev = src_in.gpio_port_event;
  end

  // Rising edge only; a held level posts once
  assign gpio_edge = src_in.gpio_port_event & ~gpio_prev_ff;

  always_comb begin
    hw_evt = 24'h000000;
    hw_evt[0] = src_in.power_fault_event;
    hw_evt[1] = src_in.external_irq_0;
    hw_evt[2] = src_in.spi_tx_event;
    hw_evt[3] = src_in.spi_rx_event;
    hw_evt[4] = gpio_edge[0];
    hw_evt[5] = src_in.external_irq_1;
    hw_evt[6] = src_in.sleep_timer_event;
    hw_evt[7] = gpio_edge[1];
    hw_evt[15] = timer_src_in.capture0_event;
    hw_evt[14] = timer_src_in.prog_interval_event;
    hw_evt[13] = timer_src_in.ms_timer_event;
    hw_evt[16] = src_in.capture1_event;
    hw_evt[17] = src_in.counter_wrap_event;
    hw_evt[18] = src_in.external_irq_2;
    hw_evt[20] = gpio_edge[2];
    hw_evt[21] = gpio_edge[3];
    hw_evt[22] = gpio_edge[4];
  end

  // ==========================================================================
  // Posted flags, masks and soft post enable
  localparam logic [23:0] IMPL = {ipv_pkg::IMPL_MASK_2, ipv_pkg::IMPL_MASK_1,
                                  ipv_pkg::IMPL_MASK_0};
  logic [23:0] posted_ff;
  logic [23:0] nxt_posted;
  logic [23:0] mask_ff;
  logic [23:0] nxt_mask;
  logic soft_post_enable_ff;
  logic nxt_soft_post_enable;
  logic [23:0] pending;
  logic [23:0] taken;
  logic [4:0] win_idx;
  logic win_valid;
  logic [7:0] win_vector;

  assign pending = posted_ff & mask_ff & IMPL;

  // Priority encoder over ascending priority level
  always_comb begin
    logic [4:0] best;
    best = 5'h1F;
    win_idx = 5'h00;
    win_valid = 1'b0;
    for (int i = 0; i < ipv_pkg::NUM_SRC; i++) begin
      if (pending[i] && ipv_pkg::PRIO_TABLE[i] < best) begin
        best = ipv_pkg::PRIO_TABLE[i];
        win_idx = 5'(i);
        win_valid = 1'b1;
      end
    end
    win_vector = win_valid ? 8'({3'b000, best} * ipv_pkg::VEC_STEP) : 8'h00;
  end

  // Core takes a vector only while its own enable is set
  always_comb begin
    taken = 24'h000000;
    if (vector_take && global_irq_enable && win_valid) begin
      taken[win_idx] = 1'b1;
    end
  end

  always_comb begin
    logic [1:0] bank;
    logic wr_bank;
    nxt_posted = posted_ff;
    nxt_mask = mask_ff;
    nxt_soft_post_enable = soft_post_enable_ff;
    bank = 2'b00;
    wr_bank = 1'b0;
    if (wr_en && lane0) begin
      case (idx)
        ipv_pkg::IDX_POSTED_CLEAR_0: begin
          bank = 2'd0;
          wr_bank = 1'b1;
        end
        ipv_pkg::IDX_POSTED_CLEAR_1: begin
          bank = 2'd1;
          wr_bank = 1'b1;
        end
        ipv_pkg::IDX_POSTED_CLEAR_2: begin
          bank = 2'd2;
          wr_bank = 1'b1;
        end
        ipv_pkg::IDX_SOURCE_MASK_0: nxt_mask[7:0] = wbyte & ipv_pkg::IMPL_MASK_0;
        ipv_pkg::IDX_SOURCE_MASK_1: nxt_mask[15:8] = wbyte & ipv_pkg::IMPL_MASK_1;
        ipv_pkg::IDX_SOURCE_MASK_2: nxt_mask[23:16] = wbyte & ipv_pkg::IMPL_MASK_2;
        ipv_pkg::IDX_SOFT_POST_CONTROL: begin
          nxt_soft_post_enable = wbyte[ipv_pkg::SOFT_POST_BIT];
        end
        default: begin
        end
      endcase
    end
    // Taken flags leave first, so a new event in the same cycle still posts
    nxt_posted = nxt_posted & ~taken;
    if (wr_bank) begin
      for (int b = 0; b < 8; b++) begin
        if (soft_post_enable_ff && wbyte[b]) begin
          nxt_posted[8*bank+b] = 1'b1;
        end else if (!soft_post_enable_ff && !wbyte[b]) begin
          nxt_posted[8*bank+b] = 1'b0;
        end
      end
    end
    // Vector write clears every pending flag; masked posts survive
    if (wr_en && lane0 && idx == ipv_pkg::IDX_VECTOR_READ_CLEAR) begin
      nxt_posted = nxt_posted & ~pending;
    end
    // Hardware set wins over any clear in the same cycle
    nxt_posted = (nxt_posted | hw_evt) & IMPL;
  end

  // ==========================================================================
  // Block status and summary interrupt
  logic [ipv_pkg::EVT_W-1:0] evt_status_ff;
  logic [ipv_pkg::EVT_W-1:0] nxt_evt_status;
  logic [ipv_pkg::EVT_W-1:0] evt_mask_ff;
  logic [ipv_pkg::EVT_W-1:0] nxt_evt_mask;
  logic had_pending_ff;

  always_comb begin
    nxt_evt_status = evt_status_ff;
    nxt_evt_mask = evt_mask_ff;
    if (rd_en && idx == ipv_pkg::IDX_IRQ_STATUS) begin
      nxt_evt_status = '0;
    end
    if (wr_en && lane0 && idx == ipv_pkg::IDX_IRQ_MASK) begin
      nxt_evt_mask = wbyte[ipv_pkg::EVT_W-1:0];
    end
    // Set after clear so an event on the read cycle is kept
    if (win_valid && !had_pending_ff) begin
      nxt_evt_status[0] = 1'b1;
    end
  end

  // ==========================================================================
  // Read mux
  logic [7:0] rbyte;

  always_comb begin
    case (idx)
      ipv_pkg::IDX_POSTED_CLEAR_0: rbyte = posted_ff[7:0];
      ipv_pkg::IDX_POSTED_CLEAR_1: rbyte = posted_ff[15:8];
      ipv_pkg::IDX_POSTED_CLEAR_2: rbyte = posted_ff[23:16];
      ipv_pkg::IDX_SOURCE_MASK_0: rbyte = mask_ff[7:0];
      ipv_pkg::IDX_SOURCE_MASK_1: rbyte = mask_ff[15:8];
      ipv_pkg::IDX_SOURCE_MASK_2: rbyte = mask_ff[23:16];
      ipv_pkg::IDX_SOFT_POST_CONTROL: rbyte = {soft_post_enable_ff, 7'h00};
      ipv_pkg::IDX_VECTOR_READ_CLEAR: rbyte = win_vector;
      ipv_pkg::IDX_IRQ_STATUS: rbyte = 8'(evt_status_ff);
      ipv_pkg::IDX_IRQ_MASK: rbyte = 8'(evt_mask_ff);
      default: rbyte = 8'h00;
    endcase
  end

  always_comb begin
    prdata = rd_en ? {24'h000000, rbyte} : 32'h00000000;
    pslverr = 1'b0;
  end

  assign core_irq_req = win_valid & global_irq_enable;
  assign core_vector = win_vector;
  assign irq = |(evt_status_ff & evt_mask_ff);

  // ==========================================================================
  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      posted_ff <= 24'h000000;
      mask_ff <= 24'h000000;
      soft_post_enable_ff <= 1'b0;
      gpio_prev_ff <= '0;
      evt_status_ff <= '0;
      evt_mask_ff <= '0;
      had_pending_ff <= 1'b0;
    end else begin
      posted_ff <= nxt_posted;
      mask_ff <= nxt_mask;
      soft_post_enable_ff <= nxt_soft_post_enable;
      gpio_prev_ff <= nxt_gpio_prev;
      evt_status_ff <= nxt_evt_status;
      evt_mask_ff <= nxt_evt_mask;
      had_pending_ff <= win_valid;
    end
  end

endmodule

// ---- hdl/ipv_pkg.sv ----
// Purpose: Shared constants and types for the interrupt post/mask/vector block
// Assumes: APB with 32-bit data; registers hold 8 bits in the low lanes
// Notes: Offsets are register indexes; byte address is four times the index
package ipv_pkg;

  // ==========================================================================
  // Register indexes and byte address width
  localparam logic [7:0] IDX_POSTED_CLEAR_0 = 8'hDA;
  localparam logic [7:0] IDX_POSTED_CLEAR_1 = 8'hDB;
  localparam logic [7:0] IDX_POSTED_CLEAR_2 = 8'hDC;
  localparam logic [7:0] IDX_SOFT_POST_CONTROL = 8'hDE;
  localparam logic [7:0] IDX_SOURCE_MASK_2 = 8'hDF;
  localparam logic [7:0] IDX_SOURCE_MASK_0 = 8'hE0;
  localparam logic [7:0] IDX_SOURCE_MASK_1 = 8'hE1;
  localparam logic [7:0] IDX_VECTOR_READ_CLEAR = 8'hE2;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hE4;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hE5;
  localparam int ADDR_W = 10;

  // ==========================================================================
  // Field layout
  localparam logic [7:0] IMPL_MASK_0 = 8'hFF;
  localparam logic [7:0] IMPL_MASK_1 = 8'hE0;
  localparam logic [7:0] IMPL_MASK_2 = 8'h77;
  localparam int SOFT_POST_BIT = 7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] VEC_STEP = 8'h04;
  localparam int NUM_SRC = 24;

  // Flat source index to priority level (bank*8+bit), 0 where reserved
  localparam logic [4:0] PRIO_TABLE [NUM_SRC] = '{
    5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h19, 5'h06,
    5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h0D, 5'h0E, 5'h0F,
    5'h10, 5'h11, 5'h12, 5'h00, 5'h14, 5'h15, 5'h16, 5'h00
  };

  // ==========================================================================
  // Block-side status bits: bit 0 a vector became available
  localparam int EVT_W = 1;

  typedef struct packed {
    logic capture0_event;
    logic prog_interval_event;
    logic ms_timer_event;
  } ipv_timer_src_t;

  typedef struct packed {
    logic [4:0] gpio_port_event;
    logic power_fault_event;
    logic external_irq_0;
    logic external_irq_1;
    logic external_irq_2;
    logic spi_tx_event;
    logic spi_rx_event;
    logic sleep_timer_event;
    logic capture1_event;
    logic counter_wrap_event;
  } ipv_src_t;

endpackage

// ---- verif/interrupt_post_mask_vector_regs_tb_top.sv ----
// Purpose: Self-checking bench for ipv_ctrl
// Assumes: Zero-wait APB slave, core model on the vector side
// Notes: Rows are {op, index, write data, expected read}
`timescale 1ns/100ps
module interrupt_post_mask_vector_regs_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, gie_on = 1'b0, slow = 1'b0;
  logic [ipv_pkg::ADDR_W-1:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, core_irq_req, irq, vector_take, global_irq_enable;
  logic [7:0] core_vector, taken_vec, rd;
  ipv_pkg::ipv_src_t src = '0;
  ipv_pkg::ipv_timer_src_t tsrc = '0;
  int n_fail = 0, checks_done = 0, cyc = 0;
  localparam logic [27:0] ROWS [43] = '{
    28'h0DA0000, 28'h0DB0000, 28'h0DC0000, 28'h0DE0000, 28'h0DF0000, 28'h0E00000,
    28'h0E10000, 28'h0E20000, 28'h1DEFF00, 28'h0DE0080, 28'h1DAFF00, 28'h0DA00FF,
    28'h1DBFF00, 28'h0DB00E0, 28'h1DCFF00, 28'h0DC0077, 28'h1DA0000, 28'h0DA00FF,
    28'h1DE0000, 28'h0DE0000, 28'h1DAFF00, 28'h0DA00FF, 28'h1DAFE00, 28'h0DA00FE,
    28'h1E0A500, 28'h0E000A5, 28'h1E1FF00, 28'h0E100E0, 28'h0E000A5, 28'h1DFFF00,
    28'h0DF0077, 28'h0E2000C, 28'h1E08000, 28'h0E20018, 28'h1E20000, 28'h0DA007E,
    28'h0DB0000, 28'h0DC0000, 28'h0E20000, 28'h100FF00, 28'h0000000, 28'h1DDFF00,
    28'h0DD0000};
  initial begin
    forever #50 pclk = ~pclk;
  end
  ipv_ctrl #(.NUM_GPIO(5)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_in(src), .timer_src_in(tsrc),
    .global_irq_enable(global_irq_enable), .vector_take(vector_take),
    .core_irq_req(core_irq_req), .core_vector(core_vector), .irq(irq));
  ipv_core_model i_core (.pclk(pclk), .presetn(presetn), .gie_on(gie_on), .slow(slow),
    .core_irq_req(core_irq_req), .core_vector(core_vector),
    .global_irq_enable(global_irq_enable), .vector_take(vector_take),
    .taken_vec(taken_vec));
  // ========
  // Tasks
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask
  task automatic end_sim;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end
  // ========
  // Sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i][24]) begin
        apb(1'b1, ROWS[i][23:16], ROWS[i][15:8]);
      end else begin
        rdchk(ROWS[i][23:16], ROWS[i][7:0]);
      end
    end
    $display("register table test done");
    apb(1'b1, 8'hDA, 8'h00);
    apb(1'b1, 8'hE5, 8'h01);
    apb(1'b1, 8'hE0, 8'h11);
    apb(1'b0, 8'hE4, 8'h00);
    for (int k = 0; k < 2; k++) begin
      src.power_fault_event <= 1'b1;
      @(posedge pclk);
      src.power_fault_event <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({7'h0, irq}, k == 0 ? 8'h01 : 8'h00);
      rdchk(8'hE4, 8'h01);
      // Read clear lands at the access edge; look one edge later
      @(posedge pclk);
      chk({7'h0, irq}, 8'h00);
      apb(1'b1, 8'hE5, 8'h00);
      apb(1'b1, 8'hE2, 8'h00);
    end
    $display("interrupt test done");
    apb(1'b1, 8'hDA, 8'h00);
    src.gpio_port_event[0] <= 1'b1;
    repeat (3) @(posedge pclk);
    rdchk(8'hDA, 8'h10);
    apb(1'b1, 8'hDA, 8'hEF);
    rdchk(8'hDA, 8'h00);
    src.gpio_port_event[0] <= 1'b0;
    $display("edge post test done");
    apb(1'b1, 8'hDE, 8'h80);
    apb(1'b1, 8'hDA, 8'h91);
    apb(1'b1, 8'hE0, 8'hFF);
    rdchk(8'hE2, 8'h04);
    rdchk(8'hDA, 8'h91);
    slow <= 1'b1;
    gie_on <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(taken_vec, 8'h18);
    gie_on <= 1'b0;
    rdchk(8'hDA, 8'h00);
    $display("core take test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(8'hE0, 8'h00);
    rdchk(8'hDE, 8'h00);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule

// ---- verif/ipv_core_model.sv ----
// Purpose: Behavioural processor core that takes vectors
// Assumes: Vector is captured on the edge that ends the take pulse
// Notes: slow puts a three-cycle wait between takes
`timescale 1ns/100ps
module ipv_core_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic gie_on,
  input wire logic slow,
  // Controller side
  input wire logic core_irq_req,
  input wire logic [7:0] core_vector,
  output logic global_irq_enable,
  output logic vector_take,
  output logic [7:0] taken_vec
);
  logic [1:0] wait_ff;
  assign global_irq_enable = gie_on;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ff <= 2'h0;
      vector_take <= 1'b0;
      taken_vec <= 8'h00;
    end else begin
      vector_take <= 1'b0;
      if (vector_take) begin
        taken_vec <= core_vector;
      end else if (core_irq_req && gie_on && wait_ff == 2'h0) begin
        vector_take <= 1'b1;
        wait_ff <= slow ? 2'h3 : 2'h0;
      end else if (wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end
    end
  end
endmodule

// ---- verif/ipv_ctrl_assertions.sv ----
// Purpose: Port-level checks of ipv_ctrl
// Assumes: One clock, async active-low reset
// Notes: Register contents are judged by the bench
`timescale 1ns/100ps
module ipv_ctrl_assertions #(
  parameter int NUM_GPIO = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ipv_pkg::ADDR_W-1:0] paddr,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sources and core
  input wire ipv_pkg::ipv_src_t src_in,
  input wire ipv_pkg::ipv_timer_src_t timer_src_in,
  input wire logic global_irq_enable,
  input wire logic vector_take,
  input wire logic core_irq_req,
  input wire logic [7:0] core_vector
);
  // ========
  // Helpers
  logic acc, rda, wra, quiet;
  logic [7:0] idx;
  assign acc = psel && penable;
  assign rda = acc && !pwrite;
  assign wra = acc && pwrite && pstrb[0];
  assign idx = paddr[9:2];
  // A live source may repost a flag, so clears are judged only when quiet
  assign quiet = (src_in == '0) && (timer_src_in == '0);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ========
  // Assertions
  zero_wait_a: assert property (acc |-> pready && !pslverr)
    else $error("access phase not ready");
  idle_rdata_a: assert property (!rda |-> prdata == 32'h0)
    else $error("read data outside a read");
  upper_zero_a: assert property (rda |-> prdata[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  vec_read_a: assert property (rda && idx == ipv_pkg::IDX_VECTOR_READ_CLEAR
    |-> prdata[7:0] == core_vector)
    else $error("vector read differs from winner");
  soft_resv_a: assert property (rda && idx == ipv_pkg::IDX_SOFT_POST_CONTROL
    |-> prdata[6:0] == 7'h00)
    else $error("soft post reserved bits set");
  bank2_resv_a: assert property (rda && (idx == ipv_pkg::IDX_POSTED_CLEAR_2
    || idx == ipv_pkg::IDX_SOURCE_MASK_2) |-> !prdata[7] && !prdata[3])
    else $error("bank 2 reserved bits set");
  req_gate_a: assert property (core_irq_req |-> global_irq_enable
    && core_vector != 8'h00)
    else $error("request without enable or vector");
  vec_step_a: assert property (core_vector[1:0] == 2'h0
    && core_vector <= 8'h64)
    else $error("vector off the table");
  vc_clear_a: assert property (wra && idx == ipv_pkg::IDX_VECTOR_READ_CLEAR
    && quiet && $past(quiet) |=> core_vector == 8'h00)
    else $error("pending left after vector write");
  take_move_a: assert property (vector_take && core_irq_req && quiet
    && $past(quiet) && !wra |=> core_vector != $past(core_vector))
    else $error("taken winner not cleared");
  take_c: cover property (vector_take && core_irq_req);
  vc_wr_c: cover property (wra && idx == ipv_pkg::IDX_VECTOR_READ_CLEAR);
  req_c: cover property ($rose(core_irq_req));
endmodule

bind ipv_ctrl ipv_ctrl_assertions #(.NUM_GPIO(NUM_GPIO)) i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pstrb, .prdata, .pready,
  .pslverr, .src_in, .timer_src_in, .global_irq_enable, .vector_take,
  .core_irq_req, .core_vector
);
